/* design/asp_pkg.sv */
package asp_pkg;
    localparam logic [11:0] ADDR_CON   = 12'h000;
    localparam logic [11:0] ADDR_BAUD  = 12'h004;
    localparam logic [11:0] ADDR_FDV   = 12'h008;
    localparam logic [11:0] ADDR_TXD   = 12'h00c;
    localparam logic [11:0] ADDR_RXD   = 12'h010;
    localparam logic [11:0] ADDR_STAT  = 12'h014;
    localparam logic [11:0] ADDR_CLR   = 12'h018;
    localparam logic [11:0] ADDR_FIFO  = 12'h01c;
    // control bit positions
    localparam int CON_R    = 0;
    localparam int CON_M9   = 1;
    localparam int CON_PEN  = 2;
    localparam int CON_ODD  = 3;
    localparam int CON_STP2 = 4;
    localparam int CON_MP   = 5;
    localparam int CON_LB   = 6;
    localparam int CON_SYNC = 7;
    localparam int CON_REN  = 8;
    localparam int CON_IRDA = 9;
    localparam int CON_FDE  = 10;
    // status bit positions
    localparam int ST_PE  = 0;
    localparam int ST_FE  = 1;
    localparam int ST_OE  = 2;
    localparam int ST_TXO = 3;
    localparam int ST_RXU = 4;
    localparam int ST_TB  = 5;
    localparam int ST_TL  = 6;
    localparam int ST_RB  = 7;
    localparam int ST_ER  = 8;
    localparam int ST_BSY = 9;
    localparam int ST_ADR = 10;
    localparam int NSTAT  = 11;
    localparam int FIFO_DEPTH = 8;
    localparam int DW         = 9;
    localparam int BAUD_W     = 13;
    localparam int FDV_W      = 9;
    localparam logic [FDV_W-1:0] FDV_MOD = 9'h1ff;
    localparam logic [3:0] OVS      = 4'hf;
    localparam logic [3:0] OVS_MID  = 4'h7;
    localparam logic [3:0] IRDA_LEN = 4'h5;
    localparam logic [3:0] TRIG_RST = 4'h1;
    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_SHIFT = 2'b01,
        TX_SYNC  = 2'b10
    } asp_tx_e;
    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_SHIFT = 2'b01,
        RX_SYNC  = 2'b10
    } asp_rx_e;
    typedef struct packed {
        logic       psel;
        logic       penable;
        logic       pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } asp_apb_req_s;
endpackage : asp_pkg

/* design/asp_async_sync_port.sv */
`timescale 1ns/1ps
`default_nettype none
module asp_async_sync_port
    import asp_pkg::*;
(
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // serial lines
    input  wire logic        rxd_in,
    output logic             rxd_out,
    output logic             rxd_oe,
    output logic             txd_out,
    // service requests
    output logic             req_tx,
    output logic             req_tb,
    output logic             req_rx,
    output logic             req_err
);
    asp_apb_req_s req;
    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

    logic [10:0]       con_q;
    logic [BAUD_W-1:0] reload_q;
    logic [FDV_W-1:0]  fdv_q;
    logic [3:0]        rx_trig_q;
    logic [3:0]        tx_trig_q;
    logic [NSTAT-1:0]  stat_q;
    logic [NSTAT-1:0]  set_ev;

    wire wr_en = req.psel && req.penable && req.pwrite;
    wire rd_en = req.psel && req.penable && !req.pwrite;
    wire mapped = (req.paddr[11:5] == 7'h00) && (req.paddr[1:0] == 2'b00);

    // queues
    logic [DW-1:0] txq_mem [FIFO_DEPTH];
    logic [DW-1:0] rxq_mem [FIFO_DEPTH];
    logic [2:0]    txq_wp_q, txq_rp_q, rxq_wp_q, rxq_rp_q;
    logic [3:0]    txq_cnt_q, rxq_cnt_q;
    wire txq_push = wr_en && mapped && req.paddr == ADDR_TXD;
    wire rxq_pop  = rd_en && mapped && req.paddr == ADDR_RXD;
    logic txq_pop, rxq_push;
    logic [DW-1:0] rx_word;
    wire txq_full  = txq_cnt_q == 4'(FIFO_DEPTH);
    wire rxq_full  = rxq_cnt_q == 4'(FIFO_DEPTH);
    wire txq_ok = txq_push && !txq_full;
    wire rxq_ok = rxq_pop && rxq_cnt_q != 4'h0;

    always_ff @(posedge pclk) begin
        if (txq_ok) begin
            txq_mem[txq_wp_q] <= req.pwdata[DW-1:0];
        end
        if (rxq_push && !rxq_full) begin
            rxq_mem[rxq_wp_q] <= rx_word;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txq_wp_q  <= 3'h0;
            txq_rp_q  <= 3'h0;
            txq_cnt_q <= 4'h0;
            rxq_wp_q  <= 3'h0;
            rxq_rp_q  <= 3'h0;
            rxq_cnt_q <= 4'h0;
        end else begin
            if (txq_ok) txq_wp_q <= txq_wp_q + 3'h1;
            if (txq_pop) txq_rp_q <= txq_rp_q + 3'h1;
            txq_cnt_q <= txq_cnt_q + 4'(txq_ok) - 4'(txq_pop);
            if (rxq_push && !rxq_full) rxq_wp_q <= rxq_wp_q + 3'h1;
            if (rxq_ok) rxq_rp_q <= rxq_rp_q + 3'h1;
            rxq_cnt_q <= rxq_cnt_q + 4'(rxq_push && !rxq_full) - 4'(rxq_ok);
        end
    end

    // baud generation
    logic [FDV_W:0]    frac_q;
    logic [BAUD_W-1:0] bcnt_q;
    logic              tick_q;
    wire fd_en = con_q[CON_FDE] ? frac_q[FDV_W] : 1'b1;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frac_q <= '0;
            bcnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            frac_q <= {1'b0, frac_q[FDV_W-1:0]} + {1'b0, fdv_q};
            tick_q <= 1'b0;
            if (!con_q[CON_R]) begin
                bcnt_q <= reload_q;
            end else if (fd_en) begin
                if (bcnt_q == '0) begin
                    bcnt_q <= reload_q;
                    tick_q <= 1'b1;
                end else begin
                    bcnt_q <= bcnt_q - 1'b1;
                end
            end
        end
    end

    // input synchroniser
    logic rxd_s1_q, rxd_s2_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxd_s1_q <= 1'b1;
            rxd_s2_q <= 1'b1;
        end else begin
            rxd_s1_q <= rxd_in;
            rxd_s2_q <= rxd_s1_q;
        end
    end

    // transmitter
    asp_tx_e        tx_st_q;
    logic [11:0]    tsh_q;
    logic [3:0]     tbits_q;
    logic [3:0]     tsub_q;
    logic           tline_q;
    logic [DW-1:0]  thold_q;
    logic           thold_v_q;
    logic           sclk_q;
    logic           txd_q;
    wire sync_m = con_q[CON_SYNC];
    wire [8:0] tdat = thold_q;
    wire tpar = ^tdat[7:0] ^ con_q[CON_ODD];
    assign txq_pop = !thold_v_q && txq_cnt_q != 4'h0;
    wire tx_last_bit = tick_q && tsub_q == OVS && tbits_q == 4'h1 && tx_st_q == TX_SHIFT;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_st_q   <= TX_IDLE;
            tsh_q     <= '1;
            tbits_q   <= 4'h0;
            tsub_q    <= 4'h0;
            tline_q   <= 1'b1;
            thold_q   <= '0;
            thold_v_q <= 1'b0;
            sclk_q    <= 1'b1;
        end else begin
            if (txq_pop) begin
                thold_q   <= txq_mem[txq_rp_q];
                thold_v_q <= 1'b1;
            end
            unique case (tx_st_q)
                TX_IDLE: begin
                    tline_q <= 1'b1;
                    sclk_q  <= 1'b1;
                    if (thold_v_q && con_q[CON_R] && tick_q) begin
                        thold_v_q <= 1'b0;
                        tsub_q    <= 4'h0;
                        if (sync_m) begin
                            tsh_q   <= {4'hf, tdat[7:0]};
                            tbits_q <= 4'h8;
                            tx_st_q <= TX_SYNC;
                        end else begin
                            // start, data LSB first, parity or ninth bit, stops
                            tsh_q <= con_q[CON_M9] ? {2'b11, (con_q[CON_PEN] ? tpar : tdat[8]), tdat[7:0], 1'b0}
                                  : (con_q[CON_PEN] ? {2'b11, tpar, tdat[7:0], 1'b0}
                                  : {3'b111, tdat[7:0], 1'b0});
                            tbits_q <= 4'd10 + 4'(con_q[CON_M9] | con_q[CON_PEN]) + 4'(con_q[CON_STP2]);
                            tx_st_q <= TX_SHIFT;
                        end
                    end
                end
                TX_SHIFT: begin
                    tline_q <= tsh_q[0];
                    if (tick_q) begin
                        tsub_q <= tsub_q + 4'h1;
                        if (tsub_q == OVS) begin
                            tsh_q   <= {1'b1, tsh_q[11:1]};
                            tbits_q <= tbits_q - 4'h1;
                            if (tbits_q == 4'h1) tx_st_q <= TX_IDLE;
                        end
                    end
                end
                TX_SYNC: begin
                    tline_q <= tsh_q[0];
                    if (tick_q) begin
                        sclk_q <= ~sclk_q;
                        if (!sclk_q) begin
                            tsh_q   <= {1'b1, tsh_q[11:1]};
                            tbits_q <= tbits_q - 4'h1;
                            if (tbits_q == 4'h1) tx_st_q <= TX_IDLE;
                        end
                    end
                end
                default: tx_st_q <= TX_IDLE;
            endcase
        end
    end

    // irda: short low pulse per zero bit
    wire tx_line = (con_q[CON_IRDA] && tx_st_q == TX_SHIFT) ? !(!tline_q && tsub_q < IRDA_LEN) : tline_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd_q   <= 1'b1;
            txd_out <= 1'b1;
            rxd_out <= 1'b1;
            rxd_oe  <= 1'b0;
        end else begin
            txd_q   <= tx_line;
            txd_out <= sync_m ? sclk_q : (con_q[CON_LB] ? 1'b1 : tx_line);
            rxd_out <= tline_q;
            rxd_oe  <= sync_m && tx_st_q == TX_SYNC;
        end
    end

    // receiver
    asp_rx_e       rx_st_q;
    logic [10:0]   rsh_q;
    logic [3:0]    rbits_q;
    logic [3:0]    rsub_q;
    wire rin = con_q[CON_LB] ? txd_q : rxd_s2_q;
    wire [3:0] rtotal = 4'd10 + 4'(con_q[CON_M9] | con_q[CON_PEN]);
    logic rx_done;
    logic pe_ev, fe_ev, rin_d_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_st_q  <= RX_IDLE;
            rsh_q    <= '0;
            rbits_q  <= 4'h0;
            rsub_q   <= 4'h0;
            rx_done  <= 1'b0;
            rx_word  <= '0;
            pe_ev    <= 1'b0;
            fe_ev    <= 1'b0;
            rin_d_q  <= 1'b1;
        end else begin
            rin_d_q <= rin;
            rx_done <= 1'b0;
            pe_ev   <= 1'b0;
            fe_ev   <= 1'b0;
            unique case (rx_st_q)
                RX_IDLE: begin
                    rsub_q <= 4'h0;
                    if (con_q[CON_REN] && con_q[CON_R]) begin
                        if (sync_m && tx_st_q == TX_IDLE && !thold_v_q) begin
                            rbits_q <= 4'h8;
                            rx_st_q <= RX_SYNC;
                        end else if (!sync_m && rin_d_q && !rin) begin
                            rbits_q <= rtotal;
                            rx_st_q <= RX_SHIFT;
                        end
                    end
                end
                RX_SHIFT: begin
                    if (tick_q) begin
                        rsub_q <= rsub_q + 4'h1;
                        if (rsub_q == OVS_MID) begin
                            rsh_q   <= {rin, rsh_q[10:1]};
                            rbits_q <= rbits_q - 4'h1;
                            if (rbits_q == 4'h1) begin
                                rx_st_q <= RX_IDLE;
                                rx_done <= 1'b1;
                                fe_ev   <= !rin;
                                rx_word <= con_q[CON_M9] ? rsh_q[10:2]
                                         : {1'b0, (con_q[CON_PEN] ? rsh_q[9:2] : rsh_q[10:3])};
                                pe_ev   <= con_q[CON_PEN] &&
                                           ((^(con_q[CON_M9] ? rsh_q[10:1] : {1'b0, rsh_q[10:2]})) != con_q[CON_ODD]);
                            end
                        end
                    end
                end
                RX_SYNC: begin
                    if (tick_q) begin
                        rsub_q <= rsub_q + 4'h1;
                        if (rsub_q[0]) begin
                            rsh_q   <= {rxd_s2_q, rsh_q[10:1]};
                            rbits_q <= rbits_q - 4'h1;
                            if (rbits_q == 4'h1) begin
                                rx_st_q <= RX_IDLE;
                                rx_done <= 1'b1;
                                rx_word <= {1'b0, rxd_s2_q, rsh_q[10:4]};
                            end
                        end
                    end
                end
                default: rx_st_q <= RX_IDLE;
            endcase
        end
    end
    // multiprocessor mode with 9-bit frames keeps only address-marked frames
    wire mp_drop = con_q[CON_MP] && con_q[CON_M9] && !rx_word[8];
    assign rxq_push = rx_done && !mp_drop && !pe_ev;

    // status: hardware set wins over software clear
    always_comb begin
        set_ev = '0;
        set_ev[ST_PE]  = pe_ev;
        set_ev[ST_FE]  = fe_ev;
        set_ev[ST_OE]  = rxq_push && rxq_full;
        set_ev[ST_TXO] = txq_push && txq_full;
        set_ev[ST_RXU] = rxq_pop && rxq_cnt_q == 4'h0;
        set_ev[ST_TB]  = txq_pop;
        set_ev[ST_TL]  = tx_last_bit;
        set_ev[ST_RB]  = rxq_push && !rxq_full;
        set_ev[ST_ADR] = rx_done && con_q[CON_MP] && rx_word[8];
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= '0;
        end else begin
            for (int i = 0; i < NSTAT; i++) begin
                if (set_ev[i]) stat_q[i] <= 1'b1;
                else if (wr_en && mapped && req.paddr == ADDR_CLR && req.pwdata[i]) stat_q[i] <= 1'b0;
            end
            stat_q[ST_ER]  <= stat_q[ST_PE] | stat_q[ST_FE] | stat_q[ST_OE];
            stat_q[ST_BSY] <= tx_st_q != TX_IDLE || rx_st_q != RX_IDLE;
        end
    end

    // service requests
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_tx  <= 1'b0;
            req_tb  <= 1'b0;
            req_rx  <= 1'b0;
            req_err <= 1'b0;
        end else begin
            req_tx  <= (4'(FIFO_DEPTH) - txq_cnt_q) >= tx_trig_q;
            req_tb  <= tx_last_bit;
            req_rx  <= rxq_cnt_q >= rx_trig_q && rxq_cnt_q != 4'h0;
            req_err <= pe_ev | fe_ev | (rxq_push && rxq_full);
        end
    end

    // apb registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            con_q     <= '0;
            reload_q  <= '0;
            fdv_q     <= '0;
            rx_trig_q <= TRIG_RST;
            tx_trig_q <= TRIG_RST;
            prdata    <= '0;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
        end else begin
            pready  <= req.psel && !req.penable;
            pslverr <= req.psel && !req.penable && !(mapped && req.paddr <= ADDR_FIFO);
            if (wr_en && mapped) begin
                unique case (req.paddr)
                    ADDR_CON:  con_q    <= req.pwdata[10:0];
                    ADDR_BAUD: reload_q <= req.pwdata[BAUD_W-1:0];
                    ADDR_FDV:  fdv_q    <= req.pwdata[FDV_W-1:0];
                    ADDR_FIFO: begin
                        rx_trig_q <= req.pwdata[3:0];
                        tx_trig_q <= req.pwdata[11:8];
                    end
                    default: ;
                endcase
            end
            if (req.psel && !req.penable && !req.pwrite) begin
                unique case (req.paddr)
                    ADDR_CON:  prdata <= {21'h0, con_q};
                    ADDR_BAUD: prdata <= {19'h0, reload_q};
                    ADDR_FDV:  prdata <= {23'h0, fdv_q};
                    ADDR_RXD:  prdata <= {23'h0, rxq_mem[rxq_rp_q]};
                    ADDR_STAT: prdata <= {21'h0, stat_q};
                    ADDR_FIFO: prdata <= {4'h0, txq_cnt_q, 4'h0, rxq_cnt_q,
                                          4'h0, tx_trig_q, 4'h0, rx_trig_q};
                    default:   prdata <= 32'h0;
                endcase
            end
        end
    end
endmodule : asp_async_sync_port
`default_nettype wire

/* tb/asp_port_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module asp_port_asserts
    import asp_pkg::*;
(
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // serial lines
    input  wire logic        rxd_in,
    input  wire logic        rxd_out,
    input  wire logic        rxd_oe,
    input  wire logic        txd_out,
    // requests
    input  wire logic        req_tx,
    input  wire logic        req_tb,
    input  wire logic        req_rx,
    input  wire logic        req_err
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence bad_addr_s;
        setup_s ##0 (paddr > 12'h01c || paddr[1:0] != 2'b00);
    endsequence
    setup_ready_a: assert property (setup_s |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    slverr_qual_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    unmapped_err_a: assert property (bad_addr_s |=> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (setup_s ##0 (paddr <= 12'h01c && paddr[1:0] == 2'b00) |=> !pslverr)
        else $error("mapped access refused");
    last_bit_a: assert property (req_tb |=> !req_tb)
        else $error("last bit request not a pulse");
    err_pulse_a: assert property (req_err |=> !req_err)
        else $error("error request not a pulse");
    reset_idle_a: assert property ($rose(presetn) |-> txd_out && !rxd_oe && !req_tb && !req_err)
        else $error("lines not idle after reset");
endmodule : asp_port_asserts
`default_nettype wire

/* tb/asp_serial_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module asp_serial_peer
    import asp_pkg::*;
#(
    parameter int BIT_CLKS = 16
) (
    // clock
    input  wire logic        clk,
    // lines
    input  wire logic        txd,
    output logic             rxd,
    // capture
    input  wire logic [3:0]  nbits,
    output logic      [11:0] cap,
    output logic      [7:0]  cap_cnt
);
    task automatic send(input logic [11:0] frame, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            rxd <= frame[i];
            repeat (BIT_CLKS - 1) @(posedge clk);
        end
        @(posedge clk);
        rxd <= 1'b1;
    endtask : send
    initial begin
        rxd = 1'b1;
        cap = '0;
        cap_cnt = '0;
        forever begin
            @(negedge txd);
            repeat (BIT_CLKS / 2) @(posedge clk);
            for (int i = 0; i < 12; i++) begin
                if (i < nbits) begin
                    repeat (BIT_CLKS) @(posedge clk);
                    cap[i] = txd;
                end
            end
            cap_cnt = cap_cnt + 8'h01;
        end
    end
endmodule : asp_serial_peer
`default_nettype wire

/* tb/asp_async_sync_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
module asp_async_sync_port_test
    import asp_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, sl;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, rxd_in, rxd_out, rxd_oe, txd_out;
    logic        req_tx, req_tb, req_rx, req_err;
    logic [3:0]  nbits;
    logic [11:0] cap;
    logic [7:0]  cap_cnt;
    int          error_cnt, samples_checked, tb_cnt, er_cnt;

    asp_async_sync_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out),
        .req_tx(req_tx), .req_tb(req_tb), .req_rx(req_rx), .req_err(req_err));
    asp_serial_peer peer_u (.clk(pclk), .txd(txd_out), .rxd(rxd_in), .nbits(nbits), .cap(cap),
        .cap_cnt(cap_cnt));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (req_tb === 1'b1) tb_cnt++;
        if (req_err === 1'b1) er_cnt++;
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1);
        rd = prdata;
        sl = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic t_regs;
        apb(1'b0, ADDR_FIFO, 32'h0);
        chk("fifo_reset", 32'h00000101, rd);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, sl});
        chk("unmapped_data", 32'h0, rd);
    endtask : t_regs

    task automatic t_tx;
        logic [31:0] con_t [3] = '{32'h5, 32'h3, 32'h11};
        logic [31:0] dat_t [3] = '{32'h03d, 32'h1a5, 32'h05a};
        logic [11:0] exp_t [3] = '{12'h33d, 12'h3a5, 12'h35a};
        int          k;
        int          t0;
        t0 = tb_cnt;
        apb(1'b1, ADDR_BAUD, 32'h0);
        for (int i = 0; i < 3; i++) begin
            nbits <= 4'ha;
            apb(1'b1, ADDR_CON, con_t[i]);
            k = int'(cap_cnt) + ((i == 2) ? 2 : 1);
            if (i == 2) apb(1'b1, ADDR_TXD, 32'h03c);
            apb(1'b1, ADDR_TXD, dat_t[i]);
            while (int'(cap_cnt) != k && k < 9999) @(posedge pclk);
            chk("tx_frame", {20'h0, exp_t[i]}, {20'h0, cap});
            repeat (16) @(posedge pclk);
        end
        chk("last_bit_reqs", t0 + 4, tb_cnt);
    endtask : t_tx

    task automatic t_rx;
        logic [11:0] frm_t [3] = '{12'h67a, 12'h47a, 12'h27a};
        logic [31:0] st_t [3] = '{32'h0, 32'h1, 32'h2};
        int          e0;
        apb(1'b1, ADDR_CON, 32'h105);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, ADDR_CLR, 32'h7ff);
            e0 = er_cnt;
            peer_u.send(frm_t[i], 11);
            repeat (24) @(posedge pclk);
            if (i == 0) chk("req_rx", 32'h1, {31'h0, req_rx});
            apb(1'b0, ADDR_STAT, 32'h0);
            chk("stat_pe_fe", st_t[i], rd & 32'h3);
            chk("err_req", e0 + ((i > 0) ? 1 : 0), er_cnt);
            if (i < 2) begin
                apb(1'b0, ADDR_FIFO, 32'h0);
                chk("rx_count", (i == 0) ? 32'h1 : 32'h0, {28'h0, rd[19:16]});
            end
            if (i == 0) begin
                apb(1'b0, ADDR_RXD, 32'h0);
                chk("rx_data", 32'h03d, rd);
            end
        end
        apb(1'b0, ADDR_RXD, 32'h0);
        chk("rx_fe_data", 32'h03d, rd);
        apb(1'b0, ADDR_RXD, 32'h0);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk("rx_underflow", 32'h1, {31'h0, rd[ST_RXU]});
    endtask : t_rx

    task automatic t_loop;
        int k;
        k = 0;
        apb(1'b1, ADDR_CON, 32'h141);
        apb(1'b1, ADDR_TXD, 32'h0a5);
        while (req_rx !== 1'b1 && k < 600) begin
            @(posedge pclk);
            k++;
        end
        apb(1'b0, ADDR_RXD, 32'h0);
        chk("loop_data", 32'h0a5, rd);
    endtask : t_loop

    task automatic t_ovf;
        apb(1'b1, ADDR_CON, 32'h0);
        apb(1'b1, ADDR_CLR, 32'h7ff);
        repeat (11) apb(1'b1, ADDR_TXD, 32'h011);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk("tx_overrun", 32'h1, {31'h0, rd[ST_TXO]});
        apb(1'b0, ADDR_FIFO, 32'h0);
        chk("tx_count", 32'h8, {28'h0, rd[27:24]});
        chk("req_tx", 32'h0, {31'h0, req_tx});
    endtask : t_ovf

    task automatic end_sim;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        end_sim();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        nbits = 4'ha;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_tx();
        t_rx();
        t_loop();
        t_ovf();
        end_sim();
    end
endmodule : asp_async_sync_port_test

bind asp_async_sync_port asp_port_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
    .txd_out(txd_out), .req_tx(req_tx), .req_tb(req_tb), .req_rx(req_rx), .req_err(req_err));
`default_nettype wire
